// ===== design/resr_event_status.sv
`timescale 1ns/10ps

// Function
// RL1 - Converter 1 power-good event sets event bit 6; host write-1 clears.
// RL2 - Converter 1 short held over 1 ms latches bit 5; write-1 clears.
// RL3 - Converter 1 current limit activity latches bit 4; write-1 clears.
// RL4 - Converter 0 power-good event sets event bit 2; write-1 clears.
// RL5 - Converter 0 short held over 1 ms latches bit 1; write-1 clears.
// RL6 - Converter 0 current limit activity latches bit 0; write-1 clears.
// RL7 - Linreg 1 power-good event sets bit 6; write-1 clears.
// RL8 - Linreg 1 short held over 1 ms latches bit 5; write-1 clears.
// RL9 - Linreg 1 current limit activity latches bit 4; write-1 clears.
// RL10 - Linreg 0 power-good event sets bit 2; write-1 clears.
// RL11 - Linreg 0 short held over 1 ms latches bit 1; write-1 clears.
// RL12 - Linreg 0 current limit activity latches bit 0; write-1 clears.
// RL13 - Global status bit 7 mirrors the power-good pin live.
// RL14 - Global status bit 4 is 1 while external clock is invalid.
// RL15 - Global status bit 3 mirrors thermal shutdown comparator.
// RL16 - Global status bit 2 mirrors thermal warning comparator.
// RL17 - Global status bit 1 mirrors input overvoltage monitor.
// RL18 - Converter summary bit is 1 while any converter flag is set.
// RL19 - Linreg summary bit is 1 while any linreg flag is set.
// RL20 - Converter status shows enable, output invalid and limit active.
// RL21 - Writing 0 keeps flags; an event beats a same-cycle clear.
module resr_event_status
  import resr_pkg::*;
(
  // Clock, reset, enable
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       clk_en,
  // Register access port
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  // Converter monitors, index 0 and 1
  input  wire logic [1:0] conv_power_good_event,
  input  wire logic [1:0] conv_short_active,
  input  wire logic [1:0] conv_limit_active,
  input  wire logic [1:0] conv_enabled_state,
  input  wire logic [1:0] conv_output_invalid,
  // Linear regulator monitors, index 0 and 1
  input  wire logic [1:0] linreg_power_good_event,
  input  wire logic [1:0] linreg_short_active,
  input  wire logic [1:0] linreg_limit_active,
  // Global monitors
  input  wire logic       power_good_pin,
  input  wire logic       ext_sync_clock_invalid,
  input  wire logic       thermal_shutdown_state,
  input  wire logic       thermal_warning_state,
  input  wire logic       input_overvoltage_state,
  // Summary outputs
  output logic            conv_summary_irq,
  output logic            linreg_summary_irq
);

  // ***********************************************************************
  // Short-circuit qualification
  // ***********************************************************************
  logic [3:0]            short_raw;
  logic [3:0]            short_qual;
  logic [RESR_CNT_W-1:0] short_cnt_reg [4];

  assign short_raw = {linreg_short_active, conv_short_active};

  // Count while the short persists; a glitch restarts the 1 ms window
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_short
      always_ff @(posedge mclk)
      begin
        if (!nrst)
          short_cnt_reg[g] <= '0;
        else if (clk_en)
        begin
          if (!short_raw[g])
            short_cnt_reg[g] <= '0;
          else if (short_cnt_reg[g] !=
                   RESR_CNT_W'(RESR_SHORT_CYCLES))
            short_cnt_reg[g] <= short_cnt_reg[g] + 1'b1; // RL2 RL5
        end
      end
      // Fires once, on reaching the count, so a cleared flag stays clear
      assign short_qual[g] = short_raw[g] &&
        (short_cnt_reg[g] == RESR_CNT_W'(RESR_SHORT_CYCLES - 1)); // RL8 RL11
    end
  endgenerate

  // ***********************************************************************
  // Event flags
  // ***********************************************************************
  logic [7:0] conv_set;
  logic [7:0] linreg_set;
  logic [7:0] conv_flags_reg;
  logic [7:0] linreg_flags_reg;
  logic [7:0] conv_flags_next;
  logic [7:0] linreg_flags_next;
  logic       conv_clr;
  logic       linreg_clr;

  // Event vectors in register bit order
  always_comb
  begin
    conv_set = 8'h00;
    conv_set[RESR_POS_PG1]    = conv_power_good_event[1];  // RL1
    conv_set[RESR_POS_SHORT1] = short_qual[1];             // RL2
    conv_set[RESR_POS_LIMIT1] = conv_limit_active[1];      // RL3
    conv_set[RESR_POS_PG0]    = conv_power_good_event[0];  // RL4
    conv_set[RESR_POS_SHORT0] = short_qual[0];             // RL5
    conv_set[RESR_POS_LIMIT0] = conv_limit_active[0];      // RL6
    linreg_set = 8'h00;
    linreg_set[RESR_POS_PG1]    = linreg_power_good_event[1]; // RL7
    linreg_set[RESR_POS_SHORT1] = short_qual[3];              // RL8
    linreg_set[RESR_POS_LIMIT1] = linreg_limit_active[1];     // RL9
    linreg_set[RESR_POS_PG0]    = linreg_power_good_event[0]; // RL10
    linreg_set[RESR_POS_SHORT0] = short_qual[2];              // RL11
    linreg_set[RESR_POS_LIMIT0] = linreg_limit_active[0];     // RL12
  end

  assign conv_clr   = reg_wr && (reg_addr == RESR_CONV_EVENT_OFS);
  assign linreg_clr = reg_wr && (reg_addr == RESR_LINREG_EVENT_OFS);

  // Set has priority over clear so no event is lost; reserved bits stay 0
  always_comb
  begin
    conv_flags_next = conv_flags_reg;
    if (conv_clr)
      conv_flags_next = conv_flags_next & ~reg_wdata;           // RL21
    conv_flags_next = (conv_flags_next | conv_set) & RESR_EVENT_MASK;
    linreg_flags_next = linreg_flags_reg;
    if (linreg_clr)
      linreg_flags_next = linreg_flags_next & ~reg_wdata;       // RL21
    linreg_flags_next = (linreg_flags_next | linreg_set) & RESR_EVENT_MASK;
  end

  // Flag storage
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      conv_flags_reg   <= RESR_RESET_VAL;
      linreg_flags_reg <= RESR_RESET_VAL;
    end
    else if (clk_en)
    begin
      conv_flags_reg   <= conv_flags_next;   // RL1 RL4
      linreg_flags_reg <= linreg_flags_next; // RL7 RL10
    end
  end

  // ***********************************************************************
  // Summary outputs
  // ***********************************************************************
  // Follow the next flag value so summaries line up with the flags
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      conv_summary_irq   <= 1'b0;
      linreg_summary_irq <= 1'b0;
    end
    else if (clk_en)
    begin
      conv_summary_irq   <= |conv_flags_next;   // RL18
      linreg_summary_irq <= |linreg_flags_next; // RL19
    end
  end

  // ***********************************************************************
  // Live status and read path
  // ***********************************************************************
  logic [7:0] global_stat;
  logic [7:0] conv_stat;
  logic [7:0] summary_stat;

  // Live bits, not latched
  always_comb
  begin
    global_stat = 8'h00;
    global_stat[RESR_POS_POWER_GOOD_PIN_PIN] = power_good_pin;          // RL13
    global_stat[RESR_POS_SYNC_BAD]  = ext_sync_clock_invalid;  // RL14
    global_stat[RESR_POS_TSD]       = thermal_shutdown_state;  // RL15
    global_stat[RESR_POS_TWARN]     = thermal_warning_state;   // RL16
    global_stat[RESR_POS_OVP]       = input_overvoltage_state; // RL17
    conv_stat = 8'h00;
    conv_stat[RESR_POS_ENABLE1] = conv_enabled_state[1];  // RL20
    conv_stat[RESR_POS_PG1]     = conv_output_invalid[1]; // RL20
    conv_stat[RESR_POS_LIMIT1]  = conv_limit_active[1];   // RL20
    conv_stat[RESR_POS_ENABLE0] = conv_enabled_state[0];  // RL20
    conv_stat[RESR_POS_PG0]     = conv_output_invalid[0]; // RL20
    conv_stat[RESR_POS_LIMIT0]  = conv_limit_active[0];   // RL20
    summary_stat = 8'h00;
    summary_stat[RESR_POS_SUM_CONV]   = |conv_flags_reg;   // RL18
    summary_stat[RESR_POS_SUM_LINREG] = |linreg_flags_reg; // RL19
  end

  // Registered read data, one cycle after the strobe; unmapped reads 0
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else if (clk_en)
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
      begin
        case (reg_addr)
          RESR_CONV_EVENT_OFS:   reg_rdata <= conv_flags_reg;
          RESR_LINREG_EVENT_OFS: reg_rdata <= linreg_flags_reg;
          RESR_GLOBAL_STAT_OFS:  reg_rdata <= global_stat;
          RESR_CONV_STAT_OFS:    reg_rdata <= conv_stat;
          RESR_SUMMARY_OFS:      reg_rdata <= summary_stat;
          default:               reg_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule

// ===== design/resr_pkg.sv
package resr_pkg;

  // ***********************************************************************
  // Register offsets
  // ***********************************************************************
  localparam logic [7:0] RESR_CONV_EVENT_OFS  = 8'h1b;
  localparam logic [7:0] RESR_LINREG_EVENT_OFS = 8'h1c;
  localparam logic [7:0] RESR_GLOBAL_STAT_OFS = 8'h1d;
  localparam logic [7:0] RESR_CONV_STAT_OFS   = 8'h1e;
  localparam logic [7:0] RESR_SUMMARY_OFS     = 8'h19;

  // ***********************************************************************
  // Field positions and reset values
  // ***********************************************************************
  localparam int RESR_POS_LIMIT0    = 0;
  localparam int RESR_POS_SHORT0    = 1;
  localparam int RESR_POS_PG0       = 2;
  localparam int RESR_POS_LIMIT1    = 4;
  localparam int RESR_POS_SHORT1    = 5;
  localparam int RESR_POS_PG1       = 6;
  localparam int RESR_POS_ENABLE0   = 3;
  localparam int RESR_POS_ENABLE1   = 7;
  localparam int RESR_POS_OVP       = 1;
  localparam int RESR_POS_TWARN     = 2;
  localparam int RESR_POS_TSD       = 3;
  localparam int RESR_POS_SYNC_BAD  = 4;
  localparam int RESR_POS_POWER_GOOD_PIN_PIN = 7;
  localparam int RESR_POS_SUM_LINREG = 6;
  localparam int RESR_POS_SUM_CONV  = 5;
  localparam logic [7:0] RESR_EVENT_MASK = 8'h77;
  localparam logic [7:0] RESR_RESET_VAL  = 8'h00;

  // ***********************************************************************
  // Short-circuit qualification time
  // ***********************************************************************
  localparam int RESR_CLK_HZ       = 20000000;
  localparam int RESR_SHORT_US     = 1000;
  // More than 1 ms: one cycle beyond the exact count
  localparam int RESR_SHORT_CYCLES =
    (RESR_CLK_HZ / 1000000) * RESR_SHORT_US + 1;
  localparam int RESR_CNT_W        = 15;

endpackage

// ===== verif/resr_event_status_properties.sv
`timescale 1ns/10ps
// ***********************************************************************
// Port checks of the event and status registers
// ***********************************************************************
module resr_event_status_properties
  import resr_pkg::*;
(
  // Every port of the block, observed only
  input wire logic       mclk, nrst, clk_en, reg_wr, reg_rd, reg_rvalid,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
  input wire logic       power_good_pin, ext_sync_clock_invalid,
  input wire logic       thermal_shutdown_state, thermal_warning_state,
  input wire logic       input_overvoltage_state,
  input wire logic       conv_summary_irq, linreg_summary_irq,
  input wire logic [1:0] conv_power_good_event, conv_short_active,
  input wire logic [1:0] conv_limit_active, conv_enabled_state,
  input wire logic [1:0] conv_output_invalid, linreg_power_good_event,
  input wire logic [1:0] linreg_short_active, linreg_limit_active
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Accepted read of any register, and writes of the converter and linreg event registers
  wire rd_ok = reg_rd && clk_en;
  wire cwr = reg_wr && reg_addr == RESR_CONV_EVENT_OFS;
  wire lwr = reg_wr && reg_addr == RESR_LINREG_EVENT_OFS;
  AST_RD_VALID: assert property (rd_ok |=> reg_rvalid)
    else $error("read not answered");
  AST_NO_VALID: assert property (clk_en && !reg_rd |=> !reg_rvalid)
    else $error("stray read valid");
  AST_GLOBAL: assert property (
    rd_ok && reg_addr == RESR_GLOBAL_STAT_OFS |=>
    reg_rdata == {$past(power_good_pin), 2'b00,
    $past(ext_sync_clock_invalid),
    $past(thermal_shutdown_state), $past(thermal_warning_state),
    $past(input_overvoltage_state), 1'b0}) else $error("global status");
  AST_CONV_STAT: assert property (
    rd_ok && reg_addr == RESR_CONV_STAT_OFS |=>
    reg_rdata == {$past(conv_enabled_state[1]),
    $past(conv_output_invalid[1]),
    1'b0, $past(conv_limit_active[1]), $past(conv_enabled_state[0]),
    $past(conv_output_invalid[0]), 1'b0, $past(conv_limit_active[0])})
    else $error("converter status");
  AST_CONV_SET: assert property (
    clk_en && |{conv_power_good_event, conv_limit_active} |=>
    conv_summary_irq) else $error("conv not set");
  AST_LIN_SET: assert property (
    clk_en && |{linreg_power_good_event, linreg_limit_active} |=>
    linreg_summary_irq) else $error("lin not set");
  AST_CONV_KEEP: assert property (conv_summary_irq && !cwr |=>
    conv_summary_irq) else $error("conv flag lost");
  AST_LIN_KEEP: assert property (linreg_summary_irq && !lwr |=>
    linreg_summary_irq) else $error("lin flag lost");
  AST_CONV_RISE: assert property ($rose(conv_summary_irq) |-> $past(|
    {conv_power_good_event, conv_short_active, conv_limit_active}))
    else $error("conv flag without cause");
  cover property (rd_ok && reg_addr == RESR_GLOBAL_STAT_OFS);
  cover property ($rose(conv_summary_irq) && !$past(|conv_limit_active));
  cover property ($fell(linreg_summary_irq));
endmodule

bind resr_event_status resr_event_status_properties chk_u (.*);

// ===== verif/resr_host_model.sv
`timescale 1ns/10ps
// ***********************************************************************
// Host model: register reads and writes at the falling edge
// ***********************************************************************
module resr_host_model
(
  // Register access port
  input  wire logic       mclk,
  input  wire logic       reg_rvalid,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  // One strobe cycle; data scrambled so a late sample cannot pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge mclk) {reg_wr, reg_wdata} = {1'b0, ~d};
  endtask
  // Data only counts when the valid pulse came with it
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk) {reg_rd, reg_addr} = {1'b1, a};
    @(negedge mclk) reg_rd = 1'b0;
    d = reg_rvalid ? reg_rdata : 8'hxx;
  endtask
endmodule

// ===== verif/resr_event_status_test.sv
`timescale 1ns/10ps
module resr_event_status_test
  import resr_pkg::*;
;
  // ***********************************************************************
  // Stimulus, host and checks
  // ***********************************************************************
  logic mclk = 1'b0, nrst = 1'b0, clk_en = 1'b1, reg_wr, reg_rd, reg_rvalid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, e;
  logic conv_summary_irq, linreg_summary_irq, power_good_pin = 1'b0;
  logic ext_sync_clock_invalid = 1'b0, thermal_shutdown_state = 1'b0;
  logic thermal_warning_state = 1'b0, input_overvoltage_state = 1'b0;
  logic [1:0] conv_power_good_event = '0, conv_short_active = '0;
  logic [1:0] conv_limit_active = '0, conv_enabled_state = '0;
  logic [1:0] conv_output_invalid = '0, linreg_power_good_event = '0;
  logic [1:0] linreg_short_active = '0, linreg_limit_active = '0;
  int err_count = 0, n_checks = 0;
  typedef struct packed {logic [4:0] g; logic [5:0] c; logic [7:0] eg, ec;}
    resr_row_s;
  // Live inputs beside the two status bytes they must give
  resr_row_s rows [4] = '{'{5'h10, 6'h21, 8'h80, 8'h81},
    '{5'h08, 6'h12, 8'h10, 8'h44}, '{5'h04, 6'h0c, 8'h08, 8'h18},
    '{5'h03, 6'h00, 8'h06, 8'h00}};
  resr_event_status dut_u (.*);
  resr_host_model host_u (.*);
  initial forever #25 mclk = ~mclk;
  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    n_checks++;
    if (g !== x)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] x);
    host_u.rd(a, rv);
    chk(rv, x);
  endtask
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Watchdog: the short test alone needs some 20000 cycles
  initial
  begin
    #3000000;
    err_count++;
    close_out;
  end
  initial
  begin
    repeat (3) @(negedge mclk);
    nrst = 1'b1;
    foreach (rows[i])
    begin
      {power_good_pin, ext_sync_clock_invalid, thermal_shutdown_state,
        thermal_warning_state, input_overvoltage_state} = rows[i].g;
      {conv_enabled_state[1], conv_output_invalid[1], conv_limit_active[1],
        conv_enabled_state[0], conv_output_invalid[0], conv_limit_active[0]}
        = rows[i].c;
      rdc(RESR_GLOBAL_STAT_OFS, rows[i].eg);
      rdc(RESR_CONV_STAT_OFS, rows[i].ec);
    end
    host_u.wr(RESR_GLOBAL_STAT_OFS, 8'hff);
    rdc(RESR_GLOBAL_STAT_OFS, 8'h06);
    rdc(8'h00, 8'h00);
    host_u.wr(RESR_CONV_EVENT_OFS, 8'hff);
    $display("status table done");
    for (int k = 0; k < 4; k++)
    begin
      @(negedge mclk);
      {conv_limit_active, conv_power_good_event} = 4'h1 << k;
      {linreg_limit_active, linreg_power_good_event} = 4'h1 << k;
      @(negedge mclk);
      {conv_limit_active, conv_power_good_event} = '0;
      {linreg_limit_active, linreg_power_good_event} = '0;
      e = (k < 2) ? 8'h04 << (4 * k) : 8'h01 << (4 * (k - 2));
      rdc(RESR_CONV_EVENT_OFS, e);
      rdc(RESR_LINREG_EVENT_OFS, e);
      chk({6'h0, conv_summary_irq, linreg_summary_irq}, 8'h03);
      host_u.wr(RESR_CONV_EVENT_OFS, ~e);
      rdc(RESR_CONV_EVENT_OFS, e);
      host_u.wr(RESR_CONV_EVENT_OFS, e);
      host_u.wr(RESR_LINREG_EVENT_OFS, e);
      rdc(RESR_LINREG_EVENT_OFS, 8'h00);
      chk({6'h0, conv_summary_irq, linreg_summary_irq}, 8'h00);
    end
    $display("event loop done");
    fork
      host_u.wr(RESR_CONV_EVENT_OFS, 8'h40);
      begin
        @(negedge mclk) conv_power_good_event = 2'b10;
        @(negedge mclk) conv_power_good_event = 2'b00;
      end
    join
    rdc(RESR_CONV_EVENT_OFS, 8'h40);
    rdc(RESR_SUMMARY_OFS, 8'h20);
    clk_en = 1'b0;
    @(negedge mclk) linreg_power_good_event = 2'b01;
    @(negedge mclk) {clk_en, linreg_power_good_event} = 3'b100;
    rdc(RESR_LINREG_EVENT_OFS, 8'h00);
    nrst = 1'b0;
    repeat (3) @(negedge mclk);
    nrst = 1'b1;
    rdc(RESR_CONV_EVENT_OFS, 8'h00);
    $display("clear, freeze and reset done");
    {conv_short_active, linreg_short_active} = 4'hf;
    repeat (19994) @(negedge mclk);
    rdc(RESR_CONV_EVENT_OFS, 8'h00);
    repeat (8) @(negedge mclk);
    rdc(RESR_CONV_EVENT_OFS, 8'h22);
    rdc(RESR_LINREG_EVENT_OFS, 8'h22);
    host_u.wr(RESR_CONV_EVENT_OFS, 8'h22);
    rdc(RESR_CONV_EVENT_OFS, 8'h00);
    $display("short test done");
    close_out;
  end
endmodule
